// *** core/ppic_top.sv ***
`timescale 1ns/1ns
// How it works
// R1 - Drive bit per port A pin: zero picks low drive, one picks high.
// R2 - Drive bits do nothing on port A pins configured as inputs.
// R3 - Port A flag, bit 3, sets when a qualifying pin condition is seen.
// R4 - Writes to the port A flag position leave the flag unchanged.
// R5 - Writing one to acknowledge bit 2 clears the port A flag.
// R6 - Acknowledge bit always reads back as zero.
// R7 - Enable bit 1 gates the port A interrupt request.
// R8 - Mode bit 0: zero senses edges only, one senses edges and levels.
// R9 - Port D pin select bit set lets that pin raise interrupts.
// R10 - Port D polarity zero: falling edge or low level, pull-up chosen.
// R11 - Port D polarity one: rising edge or high level, pull-down chosen.
// R12 - Port A request equals flag AND enable.
// R13 - In level mode, acknowledge clears only once no enabled pin active.
module ppic_top #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // AHB-Lite slave.
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic      [31:0]  hrdata,
  // Port A pins and pin control.
  input  wire logic [W-1:0] port_a_pin_in,
  input  wire logic [W-1:0] port_a_dir_out,
  output logic      [W-1:0] port_a_drive_high,
  output logic              port_a_irq_req,
  // Port D pins and pull control.
  input  wire logic [W-1:0] port_d_pin_in,
  output logic      [W-1:0] port_d_pull_up_sel,
  output logic      [W-1:0] port_d_pull_down_sel,
  // Interrupt.
  output logic              irq
);

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [W-1:0] port_a_drive_strength_bits_q;
  logic [W-1:0] port_a_edge_polarity_bits_q;
  logic [W-1:0] port_a_pin_enable_q;
  logic         port_a_irq_flag_q;
  logic         port_a_irq_request_enable_q;
  logic         port_a_detect_level_mode_q;
  logic [W-1:0] port_d_irq_pin_enable_q;
  logic [W-1:0] port_d_edge_polarity_pull_q;
  logic         port_d_detect_level_mode_q;
  logic [1:0]   irq_status_q;
  logic [1:0]   irq_mask_q;

  // ----------------------------------------------------------------
  // Bus slave state.
  // ----------------------------------------------------------------
  ppic_pkg::ppic_bus_e bus_state_q;
  logic                wr_pend_q;
  logic [7:0]          waddr_q;
  logic [7:0]          raddr_q;
  logic                addr_phase;
  logic                wr_go;
  logic [31:0]         rd_mux;

  // ----------------------------------------------------------------
  // Pin filtering and detection.
  // ----------------------------------------------------------------
  logic [W-1:0] port_a_pins;
  logic [W-1:0] port_d_pins;
  logic         a_level_hit;
  logic         a_trigger;
  logic         d_trigger;

  // Port A pins through the three-stage filter.
  ppic_sync #(.W(W)) u_sync_a (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_in     (port_a_pin_in),
    .pin_stable (port_a_pins)
  );

  // Port D pins through the three-stage filter.
  ppic_sync #(.W(W)) u_sync_d (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_in     (port_d_pin_in),
    .pin_stable (port_d_pins)
  );

  // Port A detector, steered by the mode bit and the polarity bits.
  ppic_detect #(.W(W)) u_det_a (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_val    (port_a_pins),
    .pin_en     (port_a_pin_enable_q),
    .pol_high   (port_a_edge_polarity_bits_q),
    .level_mode (port_a_detect_level_mode_q),       // [R8]
    .edge_hit   (),
    .level_hit  (a_level_hit),
    .trigger    (a_trigger)
  );

  // Port D detector; a pin outside the select mask never triggers.
  ppic_detect #(.W(W)) u_det_d (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .pin_val    (port_d_pins),
    .pin_en     (port_d_irq_pin_enable_q),           // [R9]
    .pol_high   (port_d_edge_polarity_pull_q),       // [R10] [R11]
    .level_mode (port_d_detect_level_mode_q),
    .edge_hit   (),
    .level_hit  (),
    .trigger    (d_trigger)
  );

  // ----------------------------------------------------------------
  // AHB-Lite address phase and write data phase.
  // ----------------------------------------------------------------

  // A transfer is taken when selected, ready and NONSEQ or SEQ.
  assign addr_phase = hsel & hready & htrans[1];
  assign wr_go      = wr_pend_q;

  // Writes commit in their data phase with no wait state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= 8'h00;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase & hwrite) begin
        waddr_q <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state, so a write just before a read is
  // already stored when the read data is sampled.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_state_q <= ppic_pkg::PPIC_IDLE;
      raddr_q     <= 8'h00;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h0000_0000;
    end else begin
      case (bus_state_q)
        ppic_pkg::PPIC_IDLE: begin
          if (addr_phase & ~hwrite) begin
            bus_state_q <= ppic_pkg::PPIC_READ;
            raddr_q     <= haddr[7:0];
            hreadyout   <= 1'b0;
          end
        end
        ppic_pkg::PPIC_READ: begin
          bus_state_q <= ppic_pkg::PPIC_IDLE;
          hrdata      <= rd_mux;
          hreadyout   <= 1'b1;
        end
        default: begin
          bus_state_q <= ppic_pkg::PPIC_IDLE;
          hreadyout   <= 1'b1;
        end
      endcase
    end
  end

  // Every answer is OKAY, including unmapped offsets.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp <= ppic_pkg::HRESP_OKAY;
    end else begin
      hresp <= ppic_pkg::HRESP_OKAY;
    end
  end

  // Read multiplexer; unmapped offsets and reserved bits read zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (raddr_q)
      ppic_pkg::OFS_A_DRIVE:   rd_mux[W-1:0] = port_a_drive_strength_bits_q;
      ppic_pkg::OFS_A_STATCTL: begin
        rd_mux[ppic_pkg::BIT_A_FLAG] = port_a_irq_flag_q;
        rd_mux[ppic_pkg::BIT_A_ACK]  = 1'b0;             // [R6]
        rd_mux[ppic_pkg::BIT_A_IE]   = port_a_irq_request_enable_q;
        rd_mux[ppic_pkg::BIT_A_MODE] = port_a_detect_level_mode_q;
      end
      ppic_pkg::OFS_A_POL:     rd_mux[W-1:0] = port_a_edge_polarity_bits_q;
      ppic_pkg::OFS_A_PINEN:   rd_mux[W-1:0] = port_a_pin_enable_q;
      ppic_pkg::OFS_D_PINEN:   rd_mux[W-1:0] = port_d_irq_pin_enable_q;
      ppic_pkg::OFS_D_POL:     rd_mux[W-1:0] = port_d_edge_polarity_pull_q;
      ppic_pkg::OFS_D_CTL:     begin
        rd_mux[ppic_pkg::BIT_D_MODE] = port_d_detect_level_mode_q;
      end
      ppic_pkg::OFS_IRQ_STAT:  rd_mux[1:0] = irq_status_q;
      ppic_pkg::OFS_IRQ_MASK:  rd_mux[1:0] = irq_mask_q;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------

  // Port A drive, polarity and pin enables.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_drive_strength_bits_q <= ppic_pkg::RST_A_DRIVE;
      port_a_edge_polarity_bits_q  <= ppic_pkg::RST_A_POL;
      port_a_pin_enable_q          <= ppic_pkg::RST_A_PINEN;
    end else if (wr_go) begin
      if (waddr_q == ppic_pkg::OFS_A_DRIVE) begin
        port_a_drive_strength_bits_q <= hwdata[W-1:0];
      end
      if (waddr_q == ppic_pkg::OFS_A_POL) begin
        port_a_edge_polarity_bits_q <= hwdata[W-1:0];
      end
      if (waddr_q == ppic_pkg::OFS_A_PINEN) begin
        port_a_pin_enable_q <= hwdata[W-1:0];
      end
    end
  end

  // Port A enable and mode bits; the flag position is not stored.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_irq_request_enable_q <= ppic_pkg::RST_BIT;
      port_a_detect_level_mode_q  <= ppic_pkg::RST_BIT;
    end else if (wr_go && waddr_q == ppic_pkg::OFS_A_STATCTL) begin
      port_a_irq_request_enable_q <= hwdata[ppic_pkg::BIT_A_IE];
      port_a_detect_level_mode_q  <= hwdata[ppic_pkg::BIT_A_MODE];
    end
  end

  // Port D pin selects, polarity and mode.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_d_irq_pin_enable_q     <= ppic_pkg::RST_D_PINEN;
      port_d_edge_polarity_pull_q <= ppic_pkg::RST_D_POL;
      port_d_detect_level_mode_q  <= ppic_pkg::RST_BIT;
    end else if (wr_go) begin
      if (waddr_q == ppic_pkg::OFS_D_PINEN) begin
        port_d_irq_pin_enable_q <= hwdata[W-1:0];
      end
      if (waddr_q == ppic_pkg::OFS_D_POL) begin
        port_d_edge_polarity_pull_q <= hwdata[W-1:0];
      end
      if (waddr_q == ppic_pkg::OFS_D_CTL) begin
        port_d_detect_level_mode_q <= hwdata[ppic_pkg::BIT_D_MODE];
      end
    end
  end

  // ----------------------------------------------------------------
  // Port A flag.
  // ----------------------------------------------------------------
  logic ack_wr;

  assign ack_wr = wr_go && (waddr_q == ppic_pkg::OFS_A_STATCTL)
                  && hwdata[ppic_pkg::BIT_A_ACK];

  // The flag sets on a detection and clears on an acknowledge. A new
  // detection in the acknowledge cycle wins, and in level mode a pin
  // still active keeps the flag set, so no event is lost.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_irq_flag_q <= ppic_pkg::RST_BIT;
    end else if (a_trigger) begin
      port_a_irq_flag_q <= 1'b1;                         // [R3]
    end else if (ack_wr &&
                 !(port_a_detect_level_mode_q && a_level_hit)) begin
      port_a_irq_flag_q <= 1'b0;                         // [R5] [R13]
    end
  end
  // Writing the flag position itself has no path into the flag. [R4]

  // ----------------------------------------------------------------
  // Pin control outputs.
  // ----------------------------------------------------------------

  // High drive only reaches pins that are outputs; the direction
  // input comes from the data-direction logic on the same clock.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_drive_high <= '0;
    end else begin
      port_a_drive_high <= port_a_drive_strength_bits_q
                           & port_a_dir_out;             // [R1] [R2]
    end
  end

  // Polarity bit also picks the pull device: zero up, one down.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_d_pull_up_sel   <= '1;
      port_d_pull_down_sel <= '0;
    end else begin
      port_d_pull_up_sel   <= ~port_d_edge_polarity_pull_q; // [R10]
      port_d_pull_down_sel <= port_d_edge_polarity_pull_q;  // [R11]
    end
  end

  // Request follows flag and enable one cycle later.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_a_irq_req <= 1'b0;
    end else begin
      port_a_irq_req <= port_a_irq_flag_q
                        & port_a_irq_request_enable_q;   // [R7] [R12]
    end
  end

  // ----------------------------------------------------------------
  // Sticky status, mask and interrupt line.
  // ----------------------------------------------------------------
  logic [1:0] st_set;
  logic [1:0] st_clr;

  assign st_set[ppic_pkg::BIT_ST_A] = port_a_irq_flag_q
                                      & port_a_irq_request_enable_q;
  assign st_set[ppic_pkg::BIT_ST_D] = d_trigger;
  assign st_clr = (wr_go && waddr_q == ppic_pkg::OFS_IRQ_STAT)
                  ? hwdata[1:0] : 2'h0;

  // Write one to clear; a set in the same cycle wins.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= ppic_pkg::RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~st_clr) | st_set;
    end
  end

  // Mask register, one bit per status bit.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= ppic_pkg::RST_IRQ;
    end else if (wr_go && waddr_q == ppic_pkg::OFS_IRQ_MASK) begin
      irq_mask_q <= hwdata[1:0];
    end
  end

  // Level interrupt, high while any unmasked status bit is set.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule

// *** core/ppic_pkg.sv ***
package ppic_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the AHB-Lite bus.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_A_DRIVE   = 8'h00;
  localparam logic [7:0] OFS_A_STATCTL = 8'h04;
  localparam logic [7:0] OFS_A_POL     = 8'h08;
  localparam logic [7:0] OFS_A_PINEN   = 8'h0c;
  localparam logic [7:0] OFS_D_PINEN   = 8'h10;
  localparam logic [7:0] OFS_D_POL     = 8'h14;
  localparam logic [7:0] OFS_D_CTL     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int BIT_A_FLAG  = 3;
  localparam int BIT_A_ACK   = 2;
  localparam int BIT_A_IE    = 1;
  localparam int BIT_A_MODE  = 0;
  localparam int BIT_D_MODE  = 0;
  localparam int BIT_ST_A    = 0;
  localparam int BIT_ST_D    = 1;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_A_DRIVE = 8'h00;
  localparam logic [7:0] RST_A_POL   = 8'h00;
  localparam logic [7:0] RST_A_PINEN = 8'h00;
  localparam logic [7:0] RST_D_PINEN = 8'h00;
  localparam logic [7:0] RST_D_POL   = 8'h00;
  localparam logic [1:0] RST_IRQ     = 2'h0;
  localparam logic       RST_BIT     = 1'b0;

  // ----------------------------------------------------------------
  // Bus answer codes.
  // ----------------------------------------------------------------
  localparam logic       HRESP_OKAY  = 1'b0;

  // Bus slave states.
  typedef enum logic [1:0] {
    PPIC_IDLE = 2'b01,
    PPIC_READ = 2'b10
  } ppic_bus_e;

endpackage

// *** core/ppic_sync.sv ***
`timescale 1ns/1ns
// Three-stage pin synchroniser; the held value moves only when the
// second and third stages agree, which also filters one-cycle spikes.
module ppic_sync #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Pins and filtered result.
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_stable
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Chain of flops; only s2 reads s1.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a bit once the two late stages agree on it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_stable <= '0;
    end else begin
      pin_stable <= (s2_q & s3_q) | (pin_stable & (s2_q | s3_q));
    end
  end

endmodule

// *** core/ppic_detect.sv ***
`timescale 1ns/1ns
// Per-port interrupt detector: polarity per pin, pin enables, and an
// edge-only or edge-plus-level mode.
module ppic_detect #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Filtered pins and configuration.
  input  wire logic [W-1:0] pin_val,
  input  wire logic [W-1:0] pin_en,
  input  wire logic [W-1:0] pol_high,
  input  wire logic         level_mode,
  // Detection results.
  output logic              edge_hit,
  output logic              level_hit,
  output logic              trigger
);

  logic [W-1:0] act;
  logic [W-1:0] act_prev_q;

  // A pin is active when it matches its polarity bit.
  assign act = ~(pin_val ^ pol_high);

  // Previous activity, for edge detection. Reset to active so that a
  // pin already at its active level after reset gives no false edge.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_prev_q <= '1;
    end else begin
      act_prev_q <= act;
    end
  end

  // Only enabled pins take part; the rest are masked out.
  assign edge_hit  = |(pin_en & act & ~act_prev_q);
  assign level_hit = |(pin_en & act);
  assign trigger   = edge_hit | (level_mode & level_hit);

endmodule

// *** verif/ppic_props.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bus timing and pin control checks seen at the top ports.
// ----------------------------------------------------------------
module ppic_props #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic         sys_clk,
  input wire logic         rst,
  // Bus.
  input wire logic         hsel,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic         hreadyout,
  input wire logic         hresp,
  // Pins and interrupt.
  input wire logic [W-1:0] port_a_dir_out,
  input wire logic [W-1:0] port_a_drive_high,
  input wire logic         port_a_irq_req,
  input wire logic [W-1:0] port_d_pull_up_sel,
  input wire logic [W-1:0] port_d_pull_down_sel,
  input wire logic         irq
);
  logic wr_q;

  // Marks a write data phase, so that later drops can be traced to it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) wr_q <= 1'b0;
    else if (hready) wr_q <= hsel & htrans[1] & hwrite;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_one_wait: assert property (s_rd |=> s_wait)
    else $error("read did not take exactly one wait");
  a_ready_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_write_no_wait: assert property
    (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write was stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_drive_input_off: assert property
    ((port_a_drive_high & ~$past(port_a_dir_out)) == '0)
    else $error("drive strength on an input pin");
  a_pull_one_side: assert property
    (port_d_pull_up_sel == ~port_d_pull_down_sel)
    else $error("pull selection not complementary");
  a_pull_after_write: assert property ($changed(port_d_pull_down_sel)
    |-> $past(wr_q) || $past(wr_q, 2))
    else $error("pull selection moved without a write");
  a_req_drop_write: assert property ($fell(port_a_irq_req)
    |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
    else $error("request dropped without a write");
  a_irq_drop_write: assert property ($fell(irq)
    |-> $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
    else $error("interrupt dropped without a write");
endmodule

bind ppic_top ppic_props #(.W(W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .port_a_dir_out(port_a_dir_out),
  .port_a_drive_high(port_a_drive_high),
  .port_a_irq_req(port_a_irq_req),
  .port_d_pull_up_sel(port_d_pull_up_sel),
  .port_d_pull_down_sel(port_d_pull_down_sel), .irq(irq));

// *** verif/ppic_pins.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Off-chip circuitry on the port pins.
// ----------------------------------------------------------------
module ppic_pins #(
  parameter int W = 8
) (
  // Clock.
  input wire logic         sys_clk,
  // Levels commanded by the bench.
  input wire logic [W-1:0] a_level,
  input wire logic [W-1:0] d_level,
  input wire logic [W-1:0] d_drive_en,
  // Pull selection from the block.
  input wire logic [W-1:0] port_d_pull_up_sel,
  input wire logic [W-1:0] port_d_pull_down_sel,
  // Pins into the block.
  output logic     [W-1:0] port_a_pin_in,
  output logic     [W-1:0] port_d_pin_in
);
  logic [W-1:0] wobble_q = '0;

  // Pattern for a floating pin, so a stale level never looks driven.
  always_ff @(posedge sys_clk) wobble_q <= ~wobble_q;

  assign port_a_pin_in = a_level;

  // A released port D pin follows the pull device the block selects.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (d_drive_en[i]) port_d_pin_in[i] = d_level[i];
      else if (port_d_pull_up_sel[i]) port_d_pin_in[i] = 1'b1;
      else if (port_d_pull_down_sel[i]) port_d_pin_in[i] = 1'b0;
      else port_d_pin_in[i] = wobble_q[i];
    end
  end
endmodule

// *** verif/tb_port_pin_interrupt_control.sv ***
`timescale 1ns/1ns
module tb_port_pin_interrupt_control;
  logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        a_req, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  a_dir, a_drv, a_lvl, d_lvl, d_en, a_pin, d_pin, pu, pd;
  int          failures, checks;

  // ----------------------------------------------------------------
  // Clock, bus loop-back, design and pins.
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  assign hready = hreadyout;

  ppic_top #(.W(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .port_a_pin_in(a_pin), .port_a_dir_out(a_dir),
    .port_a_drive_high(a_drv), .port_a_irq_req(a_req),
    .port_d_pin_in(d_pin), .port_d_pull_up_sel(pu),
    .port_d_pull_down_sel(pd), .irq(irq));

  ppic_pins #(.W(8)) u_pins (
    .sys_clk(sys_clk), .a_level(a_lvl), .d_level(d_lvl),
    .d_drive_en(d_en), .port_d_pull_up_sel(pu),
    .port_d_pull_down_sel(pd), .port_a_pin_in(a_pin),
    .port_d_pin_in(d_pin));

  // ----------------------------------------------------------------
  // Bus tasks and comparison.
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; the address phase is held until ready.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // Pin filter, flag, request, status and irq stages all need time.
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog; the tests need well under a thousand cycles.
  initial begin
    #500000;
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Tests.
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    a_dir = 8'h00;
    a_lvl = 8'h00;
    d_lvl = 8'hff;
    d_en = 8'hff;
    failures = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check("pull up", 32'hff, {24'h0, pu});
    for (int i = 0; i < 9; i++) rdc("reset", 8'(i * 4), 32'h0);
    wr(8'h24, 32'hff);
    rdc("hole", 8'h24, 32'h0);
    $display("test reset done");
    wr(ppic_pkg::OFS_A_DRIVE, 32'ha5);
    a_dir <= 8'h0f;
    settle(3);
    check("drive part", 32'h05, {24'h0, a_drv});
    a_dir <= 8'hff;
    settle(3);
    check("drive all", 32'ha5, {24'h0, a_drv});
    $display("test drive done");
    wr(ppic_pkg::OFS_A_PINEN, 32'h01);
    wr(ppic_pkg::OFS_A_POL, 32'h01);
    wr(ppic_pkg::OFS_IRQ_MASK, 32'h01);
    wr(ppic_pkg::OFS_A_STATCTL, 32'h02);
    a_lvl <= 8'h01;
    settle(12);
    rdc("flag", ppic_pkg::OFS_A_STATCTL, 32'h0a);
    check("req", 32'h1, {31'h0, a_req});
    check("irq", 32'h1, {31'h0, irq});
    wr(ppic_pkg::OFS_A_STATCTL, 32'h0a);
    rdc("flag kept", ppic_pkg::OFS_A_STATCTL, 32'h0a);
    wr(ppic_pkg::OFS_A_STATCTL, 32'h06);
    rdc("ack", ppic_pkg::OFS_A_STATCTL, 32'h02);
    settle(4);
    check("req low", 32'h0, {31'h0, a_req});
    wr(ppic_pkg::OFS_IRQ_STAT, 32'h01);
    settle(3);
    check("irq low", 32'h0, {31'h0, irq});
    wr(ppic_pkg::OFS_A_STATCTL, 32'h00);
    a_lvl <= 8'h00;
    settle(12);
    a_lvl <= 8'h01;
    settle(12);
    rdc("flag no ie", ppic_pkg::OFS_A_STATCTL, 32'h08);
    check("req no ie", 32'h0, {31'h0, a_req});
    rdc("stat no ie", ppic_pkg::OFS_IRQ_STAT, 32'h0);
    $display("test edge done");
    wr(ppic_pkg::OFS_A_STATCTL, 32'h07);
    settle(4);
    wr(ppic_pkg::OFS_A_STATCTL, 32'h07);
    rdc("level held", ppic_pkg::OFS_A_STATCTL, 32'h0b);
    a_lvl <= 8'h00;
    settle(12);
    wr(ppic_pkg::OFS_A_STATCTL, 32'h07);
    rdc("level ack", ppic_pkg::OFS_A_STATCTL, 32'h03);
    wr(ppic_pkg::OFS_A_STATCTL, 32'h00);
    settle(4);
    wr(ppic_pkg::OFS_IRQ_STAT, 32'h03);
    $display("test level done");
    wr(ppic_pkg::OFS_D_PINEN, 32'h01);
    wr(ppic_pkg::OFS_IRQ_MASK, 32'h02);
    d_en <= 8'h00;
    settle(12);
    rdc("d pulled", ppic_pkg::OFS_IRQ_STAT, 32'h0);
    d_en <= 8'h02;
    d_lvl <= 8'h00;
    settle(12);
    rdc("d off pin", ppic_pkg::OFS_IRQ_STAT, 32'h0);
    d_en <= 8'h03;
    settle(12);
    rdc("d fall", ppic_pkg::OFS_IRQ_STAT, 32'h02);
    check("d irq", 32'h1, {31'h0, irq});
    wr(ppic_pkg::OFS_D_POL, 32'h01);
    settle(6);
    check("pull down", 32'h01, {24'h0, pd});
    check("pull up fe", 32'hfe, {24'h0, pu});
    wr(ppic_pkg::OFS_IRQ_STAT, 32'h02);
    rdc("d clear", ppic_pkg::OFS_IRQ_STAT, 32'h0);
    d_lvl <= 8'h01;
    settle(12);
    rdc("d rise", ppic_pkg::OFS_IRQ_STAT, 32'h02);
    wr(ppic_pkg::OFS_IRQ_STAT, 32'h02);
    settle(3);
    check("d irq low", 32'h0, {31'h0, irq});
    wr(ppic_pkg::OFS_D_CTL, 32'h01);
    settle(3);
    rdc("d mode", ppic_pkg::OFS_D_CTL, 32'h01);
    rdc("d level", ppic_pkg::OFS_IRQ_STAT, 32'h02);
    wr(ppic_pkg::OFS_D_CTL, 32'h00);
    wr(ppic_pkg::OFS_IRQ_STAT, 32'h02);
    rdc("d edge only", ppic_pkg::OFS_IRQ_STAT, 32'h0);
    $display("test port d done");
    tally_and_finish();
  end
endmodule
